// ---- include/ssp_pkg.sv ----
// Constants and types shared by the serial port design.
// Contract
// R1: Data shifts out and in together; the sent byte is replaced by the received one.
// R2: Bits travel most significant first in both directions.
// R3: Master drives the serial clock; slave takes it from the external master.
// R4: Master offers four clock rates chosen by two rate select bits.
// R5: An external master never clocks the slave above a quarter of the CPU clock.
// R6: Polarity and phase are programmable; both ends use the same setting.
// R7: The system holds slave select high through each master byte.
// R8: Master select and port enable stay set only while slave select is high; as slave the code keeps port enable set with slave select low.
// R9: As master, MOSI carries data out and MISO is sampled in.
// R10: As master, writing the data register starts a transfer.
// R11: The written byte loads in parallel into the shift register, then shifts out.
// R12: Hardware sets the transfer complete flag when a byte finishes.
// R13: Interrupt requested when the flag and enable are set and the CPU mask clear.
// R14: The received byte is copied to a buffer that data reads return.
// R15: The flag clears by a status access while set, then a data read.
// R16: While the flag is set, data writes are ignored until status is read.
// R17: Each byte uses exactly eight serial clock pulses.
// R18: Phase clear captures on the first edge, phase set on the second.
// R19: Master seeing slave select low sets mode fault, drops enable and master.
// R20: A data write during a transfer is dropped and sets the collision flag.
// R21: Between bytes the master holds the clock at the polarity level.
// R22: Master rates are fixed CPU clock divisions picked by the rate bits.
package ssp_pkg;
    localparam int BYTE_W = 8;
    localparam logic [4:0] EDGE_FIRST = 5'h00;
    localparam logic [4:0] EDGE_TAIL = 5'h10;
    localparam logic [4:0] EDGE_STEP = 5'h01;
    localparam logic [2:0] SLV_FIRST = 3'h0;
    localparam logic [2:0] SLV_LAST = 3'h7;
    localparam logic [2:0] SLV_STEP = 3'h1;
    localparam logic [5:0] HALF_DIV0 = 6'h04;
    localparam logic [5:0] HALF_DIV1 = 6'h08;
    localparam logic [5:0] HALF_DIV2 = 6'h10;
    localparam logic [5:0] HALF_DIV3 = 6'h20;
    localparam logic [5:0] DIV_ZERO = 6'h00;
    localparam logic [5:0] DIV_STEP = 6'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef enum {ST_IDLE, ST_XFER} ssp_state_e;
endpackage

// ---- verilog/ssp_slave_link.sv ----
// Slave side shifter that runs on the external master's serial clock.
`timescale 1ns/100ps
module ssp_slave_link (
    // Link clock, capture edge already selected, and resets
    input wire logic i_cap_clk,
    input wire logic i_rst_n,
    input wire logic i_ss_n,
    // Serial data
    input wire logic i_mosi,
    output logic o_miso,
    // Byte exchange with the CPU domain
    input wire logic [7:0] i_tx,
    output logic [7:0] o_rx,
    output logic o_done_tgl
);
    logic [2:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] rx_r;
    logic tgl_r;

    // A high slave select ends the frame and restarts the bit count.
    wire logic frame_rst_n = i_rst_n & i_ss_n ? 1'b0 : i_rst_n;
    wire logic first_bit = (cnt_r == ssp_pkg::SLV_FIRST);
    wire logic [7:0] src = first_bit ? i_tx : sh_r;
    wire logic [7:0] shifted = {src[6:0], i_mosi};

    always_ff @(posedge i_cap_clk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            cnt_r <= ssp_pkg::SLV_FIRST;
            sh_r <= ssp_pkg::BYTE_ZERO;
        end else begin
            cnt_r <= cnt_r + ssp_pkg::SLV_STEP; // R17
            sh_r <= shifted; // R1
        end
    end

    always_ff @(posedge i_cap_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_r <= ssp_pkg::BYTE_ZERO;
            tgl_r <= 1'b0;
        end else if (cnt_r == ssp_pkg::SLV_LAST) begin
            rx_r <= shifted;
            tgl_r <= ~tgl_r;
        end
    end

    assign o_miso = first_bit ? i_tx[7] : sh_r[7]; // R2
    assign o_rx = rx_r;
    assign o_done_tgl = tgl_r;
endmodule

// ---- verilog/ssp_top.sv ----
// Byte wide full duplex serial port, master or slave, with CPU side flags.
`timescale 1ns/100ps
module ssp_top (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    // Control register write
    input wire logic I_CTRL_WR,
    input wire logic I_TRANSFER_IRQ_ENABLE,
    input wire logic I_PORT_ENABLE,
    input wire logic I_MASTER_SELECT,
    input wire logic I_CPOL,
    input wire logic I_CPHA,
    input wire logic I_RATE_SELECT_LO,
    input wire logic I_RATE_SELECT_HI,
    // Data register
    input wire logic I_DATA_WR,
    input wire logic [7:0] I_DATA_WDATA,
    input wire logic I_DATA_RD,
    output logic [7:0] O_DATA_RDATA,
    // Status register
    input wire logic I_STATUS_ACC,
    output logic O_TRANSFER_COMPLETE_FLAG,
    output logic O_WRITE_COLLISION_FLAG,
    output logic O_MODE_FAULT_FLAG,
    output logic O_PORT_ENABLE,
    output logic O_MASTER_SELECT,
    // Interrupt
    input wire logic I_CPU_IMASK,
    output logic O_IRQ,
    // Serial pins
    input wire logic I_SCK,
    output logic O_SCK,
    output logic O_SCK_OE,
    input wire logic I_MOSI,
    output logic O_MOSI,
    output logic O_MOSI_OE,
    input wire logic I_MISO,
    output logic O_MISO,
    output logic O_MISO_OE,
    input wire logic I_SS_N
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    ssp_pkg::ssp_state_e state_r;
    logic ss_m_r, ss_s_r, miso_m_r, miso_s_r;
    logic [2:0] done_sync_r;
    logic ie_r, pe_r, ms_r, cpol_r, cpha_r;
    logic [1:0] rate_r;
    logic tc_r, tc_arm_r, write_collision_flag_r, write_collision_flag_arm_r, mode_fault_flag_r, mode_fault_flag_arm_r;
    logic [5:0] div_r;
    logic [4:0] edge_r;
    logic sck_r, bit_r, irq_r;
    logic [7:0] sh_r, rbuf_r;
    logic [7:0] slv_rx;
    logic slv_tgl, slv_miso;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ss_m_r <= 1'b1;
            ss_s_r <= 1'b1;
            miso_m_r <= 1'b0;
            miso_s_r <= 1'b0;
            done_sync_r <= 3'h0;
        end else begin
            ss_m_r <= I_SS_N;
            ss_s_r <= ss_m_r;
            miso_m_r <= I_MISO;
            miso_s_r <= miso_m_r;
            done_sync_r <= {done_sync_r[1:0], slv_tgl};
        end
    end

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    wire logic mst_on = pe_r & ms_r;
    wire logic slv_on = pe_r & ~ms_r;
    wire logic xfer = (state_r == ssp_pkg::ST_XFER);
    wire logic slv_busy = slv_on & ~ss_s_r;
    wire logic busy = xfer | slv_busy;
    wire logic mode_fault = mst_on & ~ss_s_r;
    wire logic slv_done = done_sync_r[1] ^ done_sync_r[2];
    wire logic [1:0] rate_sel = {I_RATE_SELECT_HI, I_RATE_SELECT_LO};
    wire logic [5:0] half_lim = (rate_r == 2'h0) ? ssp_pkg::HALF_DIV0 :
                                (rate_r == 2'h1) ? ssp_pkg::HALF_DIV1 :
                                (rate_r == 2'h2) ? ssp_pkg::HALF_DIV2 : ssp_pkg::HALF_DIV3;
    wire logic tick = xfer & (div_r == half_lim - ssp_pkg::DIV_STEP);
    wire logic tail = tick & (edge_r == ssp_pkg::EDGE_TAIL);
    wire logic cap_edge = tick & ~tail & (edge_r[0] == cpha_r);
    wire logic lau_edge = tick & ~tail & (edge_r[0] != cpha_r) & (edge_r != ssp_pkg::EDGE_FIRST);
    wire logic [7:0] sh_shift = {sh_r[6:0], bit_r};
    wire logic [7:0] mst_rx = cpha_r ? sh_shift : sh_r;
    wire logic wr_block = tc_r & ~tc_arm_r; // R16
    wire logic wr_ok = I_DATA_WR & ~wr_block & ~busy;
    wire logic wr_coll = I_DATA_WR & ~wr_block & busy;
    wire logic start = wr_ok & mst_on & ~mode_fault;
    wire logic tc_set = tail | slv_done;
    wire logic tc_clr = tc_arm_r & I_DATA_RD;
    wire logic write_collision_flag_clr = write_collision_flag_arm_r & I_DATA_RD;
    wire logic mode_fault_flag_clr = mode_fault_flag_arm_r & I_CTRL_WR;
    wire logic ctrl_open = ~mode_fault_flag_r | mode_fault_flag_arm_r;
    wire logic cap_clk = I_SCK ^ (cpol_r ^ cpha_r);

    // ----------------------------------------------------------------
    // Control bits
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ie_r <= 1'b0;
            cpol_r <= 1'b0;
            cpha_r <= 1'b0;
            rate_r <= 2'h0;
        end else if (I_CTRL_WR) begin
            ie_r <= I_TRANSFER_IRQ_ENABLE;
            cpol_r <= I_CPOL; // R6
            cpha_r <= I_CPHA;
            rate_r <= rate_sel; // R4
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pe_r <= 1'b0;
            ms_r <= 1'b0;
        end else if (mode_fault) begin
            pe_r <= 1'b0; // R19
            ms_r <= 1'b0; // R8
        end else if (I_CTRL_WR) begin
            pe_r <= I_PORT_ENABLE & ctrl_open;
            ms_r <= I_MASTER_SELECT & ctrl_open;
        end
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            tc_r <= 1'b0;
            tc_arm_r <= 1'b0;
        end else begin
            tc_r <= tc_set | (tc_r & ~tc_clr); // R12 R15
            tc_arm_r <= ~tc_set & ~tc_clr & tc_r & (tc_arm_r | I_STATUS_ACC); // R15
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            write_collision_flag_r <= 1'b0;
            write_collision_flag_arm_r <= 1'b0;
        end else begin
            write_collision_flag_r <= wr_coll | (write_collision_flag_r & ~write_collision_flag_clr); // R20
            write_collision_flag_arm_r <= ~wr_coll & ~write_collision_flag_clr & write_collision_flag_r & (write_collision_flag_arm_r | I_STATUS_ACC);
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            mode_fault_flag_r <= 1'b0;
            mode_fault_flag_arm_r <= 1'b0;
        end else begin
            mode_fault_flag_r <= mode_fault | (mode_fault_flag_r & ~mode_fault_flag_clr); // R19
            mode_fault_flag_arm_r <= ~mode_fault & ~mode_fault_flag_clr & mode_fault_flag_r & (mode_fault_flag_arm_r | I_STATUS_ACC);
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= ie_r & (tc_r | mode_fault_flag_r) & ~I_CPU_IMASK; // R13
        end
    end

    // ----------------------------------------------------------------
    // Master sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_r <= ssp_pkg::ST_IDLE;
            div_r <= ssp_pkg::DIV_ZERO;
            edge_r <= ssp_pkg::EDGE_FIRST;
        end else begin
            unique case (state_r)
                ssp_pkg::ST_IDLE: begin
                    div_r <= ssp_pkg::DIV_ZERO;
                    edge_r <= ssp_pkg::EDGE_FIRST;
                    if (start) begin
                        state_r <= ssp_pkg::ST_XFER; // R10
                    end
                end
                ssp_pkg::ST_XFER: begin
                    div_r <= tick ? ssp_pkg::DIV_ZERO : div_r + ssp_pkg::DIV_STEP; // R22
                    if (tick) begin
                        edge_r <= edge_r + ssp_pkg::EDGE_STEP;
                    end
                    if (tail || mode_fault) begin
                        state_r <= ssp_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Serial clock: idles at the polarity level, toggles once per half period.
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sck_r <= 1'b0;
        end else if (!xfer) begin
            sck_r <= cpol_r; // R21
        end else if (tick && !tail) begin
            sck_r <= ~sck_r; // R3 R17
        end
    end

    // ----------------------------------------------------------------
    // Shift register and receive buffer
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sh_r <= ssp_pkg::BYTE_ZERO;
            bit_r <= 1'b0;
        end else begin
            if (cap_edge) begin
                bit_r <= miso_s_r; // R9 R18
            end
            if (wr_ok) begin
                sh_r <= I_DATA_WDATA; // R11
            end else if (lau_edge || (tail && cpha_r)) begin
                sh_r <= sh_shift; // R1 R2
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rbuf_r <= ssp_pkg::BYTE_ZERO;
        end else if (tail) begin
            rbuf_r <= mst_rx; // R14
        end else if (slv_done) begin
            rbuf_r <= slv_rx;
        end
    end

    // ----------------------------------------------------------------
    // Slave link
    // ----------------------------------------------------------------
    ssp_slave_link u_slave (
        .i_cap_clk(cap_clk),
        .i_rst_n(I_RSTN),
        .i_ss_n(I_SS_N),
        .i_mosi(I_MOSI),
        .o_miso(slv_miso),
        .i_tx(sh_r),
        .o_rx(slv_rx),
        .o_done_tgl(slv_tgl)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign O_DATA_RDATA = rbuf_r;
    assign O_TRANSFER_COMPLETE_FLAG = tc_r;
    assign O_WRITE_COLLISION_FLAG = write_collision_flag_r;
    assign O_MODE_FAULT_FLAG = mode_fault_flag_r;
    assign O_PORT_ENABLE = pe_r;
    assign O_MASTER_SELECT = ms_r;
    assign O_IRQ = irq_r;
    assign O_SCK = sck_r;
    assign O_SCK_OE = mst_on;
    assign O_MOSI = sh_r[7];
    assign O_MOSI_OE = mst_on;
    assign O_MISO = slv_miso;
    assign O_MISO_OE = slv_busy;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic sck_prev_r;
    logic [4:0] tog_cnt_r;
    logic [5:0] gap_r;

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sck_prev_r <= 1'b0;
            tog_cnt_r <= 5'h00;
            gap_r <= 6'h00;
        end else begin
            sck_prev_r <= sck_r;
            gap_r <= (sck_r != sck_prev_r) ? 6'h01 : gap_r + 6'h01;
            if (start) begin
                tog_cnt_r <= 5'h00;
            end else if (xfer && sck_r != sck_prev_r) begin
                tog_cnt_r <= tog_cnt_r + 5'h01;
            end
        end
    end

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RSTN);

    property p_len;
        tail |-> tog_cnt_r == ssp_pkg::EDGE_TAIL;
    endproperty
    a_len: assert property (p_len) else $error("byte did not take eight clock pulses"); // R17

    property p_rate;
        xfer && (sck_r != sck_prev_r) && tog_cnt_r != 5'h00 |-> gap_r == half_lim;
    endproperty
    a_rate: assert property (p_rate) else $error("serial clock half period wrong"); // R22

    property p_start;
        start |=> xfer && O_MOSI == $past(I_DATA_WDATA[7]);
    endproperty
    a_start: assert property (p_start) else $error("write did not start a master byte"); // R10

    property p_idle;
        !xfer && !$past(xfer) && $stable(cpol_r) |-> O_SCK == cpol_r;
    endproperty
    a_idle: assert property (p_idle) else $error("idle clock not at polarity level"); // R21

    property p_done;
        tail |=> O_TRANSFER_COMPLETE_FLAG && O_DATA_RDATA == sh_r;
    endproperty
    a_done: assert property (p_done) else $error("flag or buffer wrong at byte end"); // R14

    property p_hold;
        tc_r && !tc_arm_r && !tc_set |=> tc_r;
    endproperty
    a_hold: assert property (p_hold) else $error("flag cleared without status access"); // R15

    property p_inhibit;
        tc_r && !tc_arm_r && I_DATA_WR && !xfer |=> $stable(sh_r) && !xfer;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("write taken while flag set"); // R16

    property p_write_collision_flag;
        xfer && I_DATA_WR && !wr_block |=> write_collision_flag_r && ($stable(sh_r) || $past(lau_edge) || $past(tail));
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged"); // R20

    property p_mode_fault_flag;
        mode_fault |=> mode_fault_flag_r && !pe_r && !ms_r ##1 !xfer;
    endproperty
    a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not handled"); // R19

    property p_irq;
        ie_r && tc_r && !I_CPU_IMASK ##1 ie_r && tc_r && !I_CPU_IMASK |-> O_IRQ;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised"); // R13

    c_master: cover property (start ##[1:1000] tail);
    c_fault: cover property (xfer && mode_fault);
    c_coll: cover property (wr_coll);
    c_slave: cover property (slv_on && slv_done);
endmodule

// ---- test/ssp_slave_model.sv ----
// Behavioural external serial slave that faces the port while it is master.
`timescale 1ns/100ps
module ssp_slave_model (
    // Select and timing mode
    input wire logic i_sel_n,
    input wire logic i_cpol,
    input wire logic i_cpha,
    // Byte to send, taken on a rising load strobe
    input wire logic i_load,
    input wire logic [7:0] i_tx,
    // Serial lines
    input wire logic i_sck,
    input wire logic i_mosi,
    output logic o_miso,
    output logic [7:0] o_rx
);
    logic [7:0] sh_r = 8'h00;
    logic last_r = 1'b0;
    int n_cap = 0;
    wire cap_rise = (i_cpol == i_cpha);
    task automatic step(input logic rising);
        if (!i_sel_n) begin
            if (rising == cap_rise) begin
                o_rx = {o_rx[6:0], i_mosi};
                n_cap++;
            end else if (!i_cpha || n_cap > 0) begin
                sh_r = {sh_r[6:0], 1'b0};
            end
        end
    endtask
    initial o_rx = 8'h00;
    always @(posedge i_sck) step(1'b1);
    always @(negedge i_sck) step(1'b0);
    always @(posedge i_load) begin
        sh_r = i_tx;
        n_cap = 0;
    end
    // A deselected slave releases the line, shown as the inverse of its last level.
    always @(sh_r or i_sel_n) if (!i_sel_n) last_r = sh_r[7];
    assign o_miso = i_sel_n ? ~last_r : sh_r[7];
endmodule

// ---- test/spi_serial_port_tb_top.sv ----
// Self-checking bench of the serial port as master and as slave.
`timescale 1ns/100ps
module spi_serial_port_tb_top;
    typedef struct packed {
        logic [1:0] rate;
        logic pol;
        logic pha;
        logic ie;
        logic mask;
        logic [7:0] tx;
        logic [7:0] srx;
    } ssp_row_s;
    localparam int DLY = 5;
    localparam int LIMIT = 30000;
    ssp_row_s rows [4] = '{'{2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'hA5, 8'h3C},
        '{2'h1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h81, 8'h7E},
        '{2'h2, 1'b1, 1'b0, 1'b0, 1'b0, 8'h01, 8'h80},
        '{2'h3, 1'b1, 1'b1, 1'b1, 1'b0, 8'hFF, 8'h00}};
    logic clk = 1'b0, rstn = 1'b0, ctrl_wr = 1'b0, ie = 1'b0, pe = 1'b0, ms = 1'b0, pol = 1'b0, pha = 1'b0;
    logic data_wr = 1'b0, data_rd = 1'b0, st_acc = 1'b0, imask = 1'b0, sck_in = 1'b0, mosi_in = 1'b0, ss_n = 1'b1;
    logic m_load = 1'b0, m_sel_n = 1'b1, sck_prev = 1'b0;
    logic [1:0] rate = 2'h0;
    logic [7:0] wdata = 8'h00, m_tx = 8'h00, s_tx = 8'h6D, s_rx = 8'hB4;
    logic [7:0] rdata, m_rx;
    logic o_tc, o_write_collision_flag, o_mf, o_pe, o_ms, o_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, miso_m, o_miso, o_miso_oe;
    int n_errors = 0, n_tests = 0, cycles = 0, tog = 0, cyc = 0, half = 0;

    ssp_top ssp_top_inst (.I_CLOCK(clk), .I_RSTN(rstn), .I_CTRL_WR(ctrl_wr), .I_TRANSFER_IRQ_ENABLE(ie),
        .I_PORT_ENABLE(pe), .I_MASTER_SELECT(ms), .I_CPOL(pol), .I_CPHA(pha), .I_RATE_SELECT_LO(rate[0]),
        .I_RATE_SELECT_HI(rate[1]), .I_DATA_WR(data_wr), .I_DATA_WDATA(wdata), .I_DATA_RD(data_rd),
        .O_DATA_RDATA(rdata), .I_STATUS_ACC(st_acc), .O_TRANSFER_COMPLETE_FLAG(o_tc),
        .O_WRITE_COLLISION_FLAG(o_write_collision_flag), .O_MODE_FAULT_FLAG(o_mf), .O_PORT_ENABLE(o_pe), .O_MASTER_SELECT(o_ms),
        .I_CPU_IMASK(imask), .O_IRQ(o_irq), .I_SCK(sck_in), .O_SCK(o_sck), .O_SCK_OE(o_sck_oe), .I_MOSI(mosi_in),
        .O_MOSI(o_mosi), .O_MOSI_OE(o_mosi_oe), .I_MISO(miso_m), .O_MISO(o_miso), .O_MISO_OE(o_miso_oe),
        .I_SS_N(ss_n));
    ssp_slave_model ssp_slave_model_inst (.i_sel_n(m_sel_n), .i_cpol(pol), .i_cpha(pha), .i_load(m_load),
        .i_tx(m_tx), .i_sck(o_sck), .i_mosi(o_mosi), .o_miso(miso_m), .o_rx(m_rx));

    always #25 clk = ~clk;

    // ----------------------------------------------------------------
    // Drivers and comparisons
    // ----------------------------------------------------------------
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #DLY;
    endtask
    task automatic fail(input string what);
        n_errors++;
        $display("unexpected at %0t: %s", $time, what);
    endtask
    task automatic check_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) fail(what);
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) fail(what);
    endtask
    task automatic check_count(input int got, input int lo, input int hi, input string what);
        n_tests++;
        if (got < lo || got > hi) fail(what);
    endtask
    task automatic ctrl(input logic e, p, m, cp, ch, input logic [1:0] r);
        {ie, pe, ms, pol, pha, rate} = {e, p, m, cp, ch, r};
        ctrl_wr = 1'b1;
        tick();
        ctrl_wr = 1'b0;
        tick();
    endtask
    task automatic cpu(input logic a, r, w, input logic [7:0] d);
        {st_acc, data_rd, data_wr, wdata} = {a, r, w, d};
        tick();
        {st_acc, data_rd, data_wr} = 3'h0;
    endtask
    task automatic load_slave(input logic [7:0] b);
        m_tx = b;
        m_load = 1'b1;
        tick();
        m_load = 1'b0;
    endtask
    task automatic wait_tc();
        cyc = 0;
        tog = 0;
        sck_prev = o_sck;
        while (o_tc !== 1'b1 && cyc < 3000) begin
            tick();
            cyc++;
            if (o_sck !== sck_prev) tog++;
            sck_prev = o_sck;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail("run did not finish in time");
            summarize();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        #DLY;
        check_bit(o_sck | o_tc | o_pe | o_ms | o_irq | o_mf, 1'b0, "outputs in reset");
        check_byte(rdata, 8'h00, "buffer in reset");
        rstn = 1'b1;
        tick(3);
        m_sel_n = 1'b0;
        // Ordinary master bytes: every rate and every polarity and phase.
        foreach (rows[i]) begin
            imask = rows[i].mask;
            ctrl(rows[i].ie, 1'b1, 1'b1, rows[i].pol, rows[i].pha, rows[i].rate);
            check_bit(o_pe & o_ms & o_sck_oe & o_mosi_oe, 1'b1, "master enabled");
            check_bit(o_sck, rows[i].pol, "idle clock level");
            load_slave(rows[i].srx);
            half = 4 << rows[i].rate;
            cpu(1'b0, 1'b0, 1'b1, rows[i].tx);
            check_bit(o_mosi, rows[i].tx[7], "first bit out");
            wait_tc();
            check_count(cyc, 17 * half, 17 * half + 1, "byte duration");
            check_count(tog, 16, 16, "clock edges per byte");
            check_byte(m_rx, rows[i].tx, "byte seen by slave");
            check_byte(rdata, rows[i].srx, "byte received");
            check_bit(o_sck, rows[i].pol, "clock back at idle");
            tick(2);
            check_bit(o_irq, rows[i].ie & ~rows[i].mask, "transfer request");
            cpu(1'b1, 1'b0, 1'b0, 8'h00);
            tick();
            check_bit(o_tc, 1'b1, "flag after status only");
            cpu(1'b0, 1'b1, 1'b0, 8'h00);
            tick();
            check_bit(o_tc | o_irq, 1'b0, "flag cleared");
        end
        // Write during a transfer, then a write while the flag is unarmed.
        imask = 1'b0;
        ctrl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        load_slave(8'h5A);
        cpu(1'b0, 1'b0, 1'b1, 8'hC3);
        tick(3);
        cpu(1'b0, 1'b0, 1'b1, 8'h0F);
        tick();
        check_bit(o_write_collision_flag, 1'b1, "collision flag");
        check_bit(o_irq, 1'b0, "no collision request");
        wait_tc();
        check_byte(m_rx, 8'hC3, "transfer kept its byte");
        check_byte(rdata, 8'h5A, "collision byte received");
        cpu(1'b0, 1'b0, 1'b1, 8'h99);
        tick(40);
        check_byte(m_rx, 8'hC3, "inhibited write sent");
        cpu(1'b1, 1'b0, 1'b0, 8'h00);
        tick();
        cpu(1'b0, 1'b1, 1'b0, 8'h00);
        tick();
        check_bit(o_tc | o_write_collision_flag, 1'b0, "flags cleared");
        // Slave select pulled low under a master.
        ss_n = 1'b0;
        tick(5);
        check_bit(o_mf & ~o_pe & ~o_ms & o_irq, 1'b1, "mode fault");
        ss_n = 1'b1;
        tick(3);
        ctrl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        check_bit(o_pe | o_ms, 1'b0, "enable refused");
        cpu(1'b1, 1'b0, 1'b0, 8'h00);
        ctrl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 2'h0);
        check_bit(~o_mf & o_pe & o_ms, 1'b1, "fault cleared");
        // Slave byte clocked by an external master on its own clock.
        ctrl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
        m_sel_n = 1'b1;
        cpu(1'b0, 1'b0, 1'b1, s_tx);
        check_bit(o_sck_oe | o_mosi_oe, 1'b0, "slave drives no clock");
        ss_n = 1'b0;
        tick(3);
        check_bit(o_miso_oe, 1'b1, "slave drives data");
        #3;
        for (int b = 7; b >= 0; b--) begin
            mosi_in = s_rx[b];
            #130;
            check_bit(o_miso, s_tx[b], "slave bit out");
            sck_in = 1'b1;
            #130;
            sck_in = 1'b0;
        end
        mosi_in = ~mosi_in;
        wait_tc();
        check_byte(rdata, s_rx, "slave byte received");
        ss_n = 1'b1;
        summarize();
    end
endmodule
